/* File: include/rcpm_pkg.sv */
/*
 * Package for the reset cause and power mode block: register offsets,
 * field positions, reset values and mode encoding.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
package rcpm_pkg;

    localparam logic [11:0] REG_GATE_OFS   = 12'h0f80;
    localparam logic [11:0] REG_CAUSE_OFS  = 12'h0ff0;
    localparam logic [11:0] REG_MODE_OFS   = 12'h0ff4;
    localparam logic [11:0] REG_WDCTL_OFS  = 12'h0ff8;

    localparam int          POWER_UP_BIT   = 7;
    localparam int          SLEEP_WAKE_BIT = 6;
    localparam int          WD_TIMEOUT_BIT = 5;
    localparam int          PIN_RESET_BIT  = 4;

    localparam int          BROWNOUT_BIT   = 4;
    localparam int          CONVERTER_BIT  = 2;
    localparam int          MATCHER_BIT    = 1;

    localparam logic [7:0]  GATE_RESET     = 8'h80;
    localparam logic [7:0]  GATE_WMASK     = 8'hff;
    localparam logic [3:0]  CAUSE_RESET    = 4'h0;
    localparam logic [7:0]  WDCTL_RESET    = 8'h00;

    typedef enum logic [1:0] {
        RCPM_ACTIVE,
        RCPM_HALT,
        RCPM_SLEEP
    } rcpm_mode_e;

endpackage

/* File: rtl/rcpm_sync.sv */
/*
 * Two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes the inputs are levels held far longer than one pclk period.
 */
`timescale 1ns/1ps
`default_nettype none
module rcpm_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/rcpm_top.sv */
/*
 * Reset cause record, low-power mode control and peripheral power gating,
 * with an APB slave for the registers.
 * Assumes reset event strobes are one-cycle pulses from pclk logic, and
 * that presetn is the power-on reset (the only reset that clears gating).
 */
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rcpm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        system_reset_n,
    input  wire logic        pin_reset_evt,
    input  wire logic        wd_timeout_evt,
    input  wire logic        debugger_reset_evt,
    input  wire logic        debug_pin_n,
    input  wire logic        gpio_wake_evt,
    input  wire logic        cpu_stop_exec,
    input  wire logic        cpu_halt_exec,
    input  wire logic        irq_pending,
    input  wire logic        brownout_reset_evt,
    input  wire logic        wd_osc_enable,
    input  wire logic        wd_enable,
    input  wire logic        brownout_stop_option,
    input  wire logic        brownout_flash_enable,
    output logic             cpu_run,
    output logic             sysclk_enable,
    output logic             main_osc_enable,
    output logic             crystal_pins_gpio,
    output logic             wd_osc_run,
    output logic             wd_logic_run,
    output logic             brownout_active,
    output logic             converter_enable,
    output logic             voltage_matcher_enable,
    output logic             periph_enable,
    output logic      [7:0]  wd_control,
    output logic             wd_control_wr
);

    logic                 dbg_low_s;
    logic                 sreset_n_s;
    logic                 sreset_n_d_ff;
    logic [3:0]           cause_ff;
    logic [3:0]           nxt_cause;
    logic [7:0]           gate_ff;
    logic                 mode_ff;
    rcpm_pkg::rcpm_mode_e nxt_mode;
    logic                 wr_acc;
    logic                 rd_acc;
    logic                 sys_rst_evt;
    logic                 in_sleep;

    rcpm_sync #(
        .W (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({~debug_pin_n, system_reset_n}),
        .q       ({dbg_low_s, sreset_n_s})
    );

    assign wr_acc   = psel && penable && pwrite;
    assign rd_acc   = psel && penable && !pwrite;
    assign in_sleep = (mode_ff == 1'b1);

    // Warm reset edge; gating register deliberately ignores it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Low like the synchroniser, so release makes no false edge
            sreset_n_d_ff <= 1'b0;
        end else begin
            sreset_n_d_ff <= sreset_n_s;
        end
    end
    assign sys_rst_evt = sreset_n_d_ff && !sreset_n_s;

    // Cause flags; events win over a same-cycle read clear
    always_comb begin
        nxt_cause = cause_ff;
        if (rd_acc && paddr == rcpm_pkg::REG_CAUSE_OFS) begin
            nxt_cause = rcpm_pkg::CAUSE_RESET;
        end
        if (debugger_reset_evt || (in_sleep && dbg_low_s)) begin
            nxt_cause = 4'b1000;
        end else if (pin_reset_evt) begin
            nxt_cause = 4'b0001;
        end else if (wd_timeout_evt && in_sleep) begin
            nxt_cause = 4'b0110;
        end else if (wd_timeout_evt) begin
            nxt_cause = 4'b0010;
        end else if (gpio_wake_evt && in_sleep) begin
            nxt_cause = 4'b0100;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_ff <= 4'b1000;
        end else begin
            cause_ff <= nxt_cause;
        end
    end

    // Only power-on clears the gating register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_ff <= rcpm_pkg::GATE_RESET;
        end else if (wr_acc && paddr == rcpm_pkg::REG_GATE_OFS) begin
            gate_ff <= pwdata[7:0] & rcpm_pkg::GATE_WMASK;
        end
    end

    // Power mode
    always_comb begin
        nxt_mode = rcpm_pkg::RCPM_ACTIVE;
        unique case (mode_sel())
            rcpm_pkg::RCPM_ACTIVE: nxt_mode = rcpm_pkg::RCPM_ACTIVE;
            default:               nxt_mode = rcpm_pkg::RCPM_ACTIVE;
        endcase
    end

    function automatic rcpm_pkg::rcpm_mode_e mode_sel();
        return rcpm_pkg::RCPM_ACTIVE;
    endfunction

    rcpm_pkg::rcpm_mode_e st_ff;
    rcpm_pkg::rcpm_mode_e nxt_st;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            rcpm_pkg::RCPM_ACTIVE: begin
                if (cpu_stop_exec) begin
                    nxt_st = rcpm_pkg::RCPM_SLEEP;
                end else if (cpu_halt_exec) begin
                    nxt_st = rcpm_pkg::RCPM_HALT;
                end
            end
            rcpm_pkg::RCPM_HALT: begin
                if (irq_pending || wd_timeout_evt || pin_reset_evt
                    || brownout_reset_evt || sys_rst_evt) begin
                    nxt_st = rcpm_pkg::RCPM_ACTIVE;
                end
            end
            rcpm_pkg::RCPM_SLEEP: begin
                if (wd_timeout_evt || gpio_wake_evt || pin_reset_evt
                    || dbg_low_s || sys_rst_evt) begin
                    nxt_st = rcpm_pkg::RCPM_ACTIVE;
                end
            end
            default: nxt_st = rcpm_pkg::RCPM_ACTIVE;
        endcase
        if (debugger_reset_evt) begin
            nxt_st = rcpm_pkg::RCPM_ACTIVE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= rcpm_pkg::RCPM_ACTIVE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= 1'b0;
        end else begin
            mode_ff <= (nxt_st == rcpm_pkg::RCPM_SLEEP);
        end
    end

    // Mode outputs registered from nxt_st change in the same cycle as st_ff; wd_osc_run and wd_logic_run follow their enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_run           <= 1'b1;
            sysclk_enable     <= 1'b1;
            main_osc_enable   <= 1'b1;
            crystal_pins_gpio <= 1'b0;
            periph_enable     <= 1'b1;
            wd_osc_run        <= 1'b0;
            wd_logic_run      <= 1'b0;
        end else begin
            cpu_run           <= (nxt_st == rcpm_pkg::RCPM_ACTIVE);
            sysclk_enable     <= (nxt_st != rcpm_pkg::RCPM_SLEEP);
            main_osc_enable   <= (nxt_st != rcpm_pkg::RCPM_SLEEP);
            crystal_pins_gpio <= (nxt_st == rcpm_pkg::RCPM_SLEEP);
            periph_enable     <= (nxt_st != rcpm_pkg::RCPM_SLEEP);
            wd_osc_run        <= wd_osc_enable;
            wd_logic_run      <= wd_enable;
        end
    end

    // Peripheral enables from gating and mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_active        <= 1'b0;
            converter_enable       <= 1'b0;
            voltage_matcher_enable <= 1'b0;
        end else begin
            brownout_active        <= !gate_ff[rcpm_pkg::BROWNOUT_BIT]
                && brownout_flash_enable
                && (nxt_st != rcpm_pkg::RCPM_SLEEP
                    || brownout_stop_option);
            converter_enable       <= !gate_ff[rcpm_pkg::CONVERTER_BIT]
                && nxt_st != rcpm_pkg::RCPM_SLEEP;
            voltage_matcher_enable <= !gate_ff[rcpm_pkg::MATCHER_BIT]
                && nxt_st != rcpm_pkg::RCPM_SLEEP;
        end
    end

    // Watchdog control write port shares the status address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_control    <= rcpm_pkg::WDCTL_RESET;
            wd_control_wr <= 1'b0;
        end else begin
            wd_control_wr <= wr_acc && paddr == rcpm_pkg::REG_CAUSE_OFS;
            if (wr_acc && paddr == rcpm_pkg::REG_CAUSE_OFS) begin
                wd_control <= pwdata[7:0];
            end
        end
    end

    // APB: zero wait state, read data registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    rcpm_pkg::REG_GATE_OFS:
                        prdata <= {24'h00_0000, gate_ff};
                    rcpm_pkg::REG_CAUSE_OFS:
                        prdata <= {24'h00_0000, cause_ff, 4'h0};
                    rcpm_pkg::REG_MODE_OFS:
                        prdata <= {30'h0000_0000, st_ff};
                    default:
                        pslverr <= psel && !penable
                            && paddr != rcpm_pkg::REG_WDCTL_OFS;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* File: dv/rcpm_src_model.sv */
/* Event source model: CPU instruction strobes and reset sources.
   Assumes the bench asks for one event at a time. */
`timescale 1ns/1ps
`default_nettype none
module rcpm_src_model (
    input  wire logic       pclk,
    input  wire logic       fire,
    input  wire logic [2:0] code,
    output logic            pin_reset_evt,
    output logic            wd_timeout_evt,
    output logic            debugger_reset_evt,
    output logic            gpio_wake_evt,
    output logic            cpu_stop_exec,
    output logic            cpu_halt_exec,
    output logic            irq_pending,
    output logic            brownout_reset_evt
);
    logic [7:0] pulse_ff;
    // Registered so each strobe lasts exactly one pclk cycle
    always_ff @(posedge pclk)
        pulse_ff <= fire ? 8'h01 << code : 8'h00;
    assign {brownout_reset_evt, irq_pending, cpu_halt_exec, cpu_stop_exec,
            gpio_wake_evt, debugger_reset_evt, wd_timeout_evt,
            pin_reset_evt} = pulse_ff;
endmodule
`default_nettype wire

/* File: dv/rcpm_monitor.sv */
/* Port checker for rcpm_top.
   Assumes a bind to every rcpm_top instance. */
`timescale 1ns/1ps
`default_nettype none
module rcpm_monitor (
    input wire logic        pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        cpu_stop_exec, cpu_halt_exec, irq_pending,
    input wire logic        pin_reset_evt, wd_timeout_evt, gpio_wake_evt,
    input wire logic        debugger_reset_evt, brownout_reset_evt,
    input wire logic        cpu_run, sysclk_enable, main_osc_enable,
    input wire logic        crystal_pins_gpio, periph_enable, wd_osc_run,
    input wire logic        wd_logic_run, wd_osc_enable, wd_enable,
    input wire logic [7:0]  wd_control,
    input wire logic        wd_control_wr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    wire rd_c = acc && !pwrite && paddr == rcpm_pkg::REG_CAUSE_OFS;
    wire wr_w = acc && pwrite && paddr == rcpm_pkg::REG_CAUSE_OFS;
    wire quiet = !(irq_pending || pin_reset_evt || wd_timeout_evt ||
        gpio_wake_evt || debugger_reset_evt || brownout_reset_evt);
    logic [7:0] last_ff;
    always_ff @(posedge pclk)
        if (wr_w) last_ff <= pwdata[7:0];
    sequence s_rd_twice;
        rd_c && quiet ##1 quiet [*2] ##1 rd_c && quiet;
    endsequence
    sequence s_halted;
        !cpu_run && sysclk_enable;
    endsequence
    chk_rsvd_zero: assert property (
        rd_c |-> prdata[31:8] == 24'h00_0000 && prdata[3:0] == 4'h0)
        else $error("reserved status bits not zero");
    chk_read_clear: assert property (
        s_rd_twice |-> prdata[7:4] == 4'h0)
        else $error("status flags survived a read");
    chk_halt_mode: assert property (
        cpu_halt_exec && cpu_run && quiet |-> ##[1:2]
        (s_halted ##0 main_osc_enable && periph_enable))
        else $error("halt mode outputs wrong");
    chk_sleep_mode: assert property (
        cpu_stop_exec && cpu_run && quiet |-> ##[1:2] (!cpu_run &&
        !sysclk_enable && !main_osc_enable && crystal_pins_gpio &&
        !periph_enable))
        else $error("sleep mode outputs wrong");
    chk_sleep_wdog: assert property (
        !sysclk_enable && $stable(wd_osc_enable) && $stable(wd_enable)
        |-> wd_osc_run == wd_osc_enable && wd_logic_run == wd_enable)
        else $error("watchdog run state wrong in sleep");
    chk_halt_exit: assert property (
        s_halted ##0 (irq_pending || wd_timeout_evt || pin_reset_evt ||
        brownout_reset_evt) |-> ##[1:2] cpu_run)
        else $error("halt not left on wake event");
    chk_wdctl_wr: assert property (
        wr_w |-> ##[1:2] (wd_control_wr && wd_control == last_ff))
        else $error("watchdog control write lost");
    chk_wdctl_only: assert property (
        wd_control_wr |-> $past(wr_w) || $past(wr_w, 2))
        else $error("spurious watchdog control strobe");
endmodule
bind rcpm_top rcpm_monitor u_mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .pready, .paddr, .pwdata, .prdata, .cpu_stop_exec,
    .cpu_halt_exec, .irq_pending, .pin_reset_evt, .wd_timeout_evt,
    .gpio_wake_evt, .debugger_reset_evt, .brownout_reset_evt, .cpu_run,
    .sysclk_enable, .main_osc_enable, .crystal_pins_gpio, .periph_enable,
    .wd_osc_run, .wd_logic_run, .wd_osc_enable, .wd_enable, .wd_control,
    .wd_control_wr);
`default_nettype wire

/* File: dv/tb.sv */
/* Self-checking bench for rcpm_top.
   Assumes the event model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [11:0] CS = rcpm_pkg::REG_CAUSE_OFS;
    localparam logic [11:0] GT = rcpm_pkg::REG_GATE_OFS;
    localparam logic [11:0] MD = rcpm_pkg::REG_MODE_OFS;
    localparam logic [2:0]  EXITS [4] = '{3'h6, 3'h1, 3'h0, 3'h7};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, fire = 0, sys_n = 1, dbg_n = 1;
    logic [2:0] code = 3'h0;
    logic wd_osc_en = 1, wd_en = 0, bo_opt = 0;
    logic [7:0] wd_control;
    logic pin_reset_evt, wd_timeout_evt, debugger_reset_evt, gpio_wake_evt;
    logic cpu_stop_exec, cpu_halt_exec, irq_pending, brownout_reset_evt;
    logic converter_enable, voltage_matcher_enable, brownout_active;
    int failures = 0, num_checks = 0, cyc = 0;
    always #5 pclk = ~pclk;
    rcpm_src_model src (.pclk, .fire, .code, .pin_reset_evt,
        .wd_timeout_evt, .debugger_reset_evt, .gpio_wake_evt,
        .cpu_stop_exec, .cpu_halt_exec, .irq_pending, .brownout_reset_evt);
    rcpm_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .system_reset_n(sys_n),
        .pin_reset_evt, .wd_timeout_evt, .debugger_reset_evt,
        .debug_pin_n(dbg_n), .gpio_wake_evt, .cpu_stop_exec, .cpu_halt_exec,
        .irq_pending, .brownout_reset_evt, .wd_osc_enable(wd_osc_en),
        .wd_enable(wd_en), .brownout_stop_option(bo_opt),
        .brownout_flash_enable(1'b1), .cpu_run(), .sysclk_enable(),
        .main_osc_enable(), .crystal_pins_gpio(), .wd_osc_run(),
        .wd_logic_run(), .brownout_active, .converter_enable,
        .voltage_matcher_enable, .periph_enable(), .wd_control,
        .wd_control_wr());
    task automatic check(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check("register", e, rd);
    endtask
    task automatic ev(input logic [2:0] c);
        @(posedge pclk);
        code <= c;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // 0 debug pin, 1 warm reset, other power-on reset
    task automatic pulse_low(input int which);
        unique case (which)
            0: dbg_n <= 1'b0;
            1: sys_n <= 1'b0;
            default: presetn <= 1'b0;
        endcase
        repeat (6) @(posedge pclk);
        unique case (which)
            0: dbg_n <= 1'b1;
            1: sys_n <= 1'b1;
            default: presetn <= 1'b1;
        endcase
        repeat (6) @(posedge pclk);
    endtask
    task automatic t_cause();
        ev(3'h1);
        rreg(CS, 32'h0000_0020);
        rreg(CS, 32'h0000_0000);
        ev(3'h0);
        rreg(CS, 32'h0000_0010);
        ev(3'h0);
        ev(3'h4);
        ev(3'h3);
        rreg(CS, 32'h0000_0040);
        ev(3'h4);
        ev(3'h3);
        ev(3'h1);
        rreg(CS, 32'h0000_0020);
        ev(3'h1);
        ev(3'h4);
        ev(3'h3);
        rreg(CS, 32'h0000_0040);
        ev(3'h4);
        ev(3'h1);
        rreg(CS, 32'h0000_0060);
        ev(3'h2);
        rreg(CS, 32'h0000_0080);
        ev(3'h4);
        pulse_low(0);
        rreg(CS, 32'h0000_0080);
        $display("t_cause done");
    endtask
    task automatic t_halt();
        for (int i = 0; i < 4; i++) begin
            ev(3'h5);
            rreg(MD, 32'h0000_0001);
            ev(EXITS[i]);
            rreg(MD, 32'h0000_0000);
        end
        $display("t_halt done");
    endtask
    task automatic t_gate();
        rreg(GT, 32'h0000_0080);
        apb(1'b1, GT, 32'h0000_0096);
        rreg(GT, 32'h0000_0096);
        check("conv", 32'h0, {31'h0, converter_enable});
        check("cmp", 32'h0, {31'h0, voltage_matcher_enable});
        check("bo", 32'h0, {31'h0, brownout_active});
        apb(1'b1, GT, 32'h0000_0084);
        pulse_low(1);
        rreg(GT, 32'h0000_0084);
        check("conv", 32'h0, {31'h0, converter_enable});
        check("cmp", 32'h1, {31'h0, voltage_matcher_enable});
        check("bo", 32'h1, {31'h0, brownout_active});
        pulse_low(2);
        rreg(GT, 32'h0000_0080);
        rreg(CS, 32'h0000_0080);
        $display("t_gate done");
    endtask
    task automatic t_wdctl();
        apb(1'b1, CS, 32'h0000_005a);
        rreg(CS, 32'h0000_0000);
        check("wdctl", 32'h5a, {24'h0, wd_control});
        apb(1'b0, 12'h100, 32'h0000_0000);
        check("slverr", 32'h1, {31'h0, err});
        check("unmapped", 32'h0, rd);
        $display("t_wdctl done");
    endtask
    task automatic t_sleep();
        wd_osc_en <= 1'b0;
        wd_en <= 1'b1;
        bo_opt <= 1'b1;
        ev(3'h4);
        check("bo", 32'h1, {31'h0, brownout_active});
        rreg(MD, 32'h0000_0002);
        bo_opt <= 1'b0;
        repeat (2) @(posedge pclk);
        check("bo", 32'h0, {31'h0, brownout_active});
        ev(3'h3);
        check("bo", 32'h1, {31'h0, brownout_active});
        rreg(MD, 32'h0000_0000);
        $display("t_sleep done");
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_cause();
        t_halt();
        t_gate();
        t_wdctl();
        t_sleep();
        summarize();
    end
endmodule
`default_nettype wire
